// *** sra_pkg.sv ***
// Purpose: shared constants and types for the serial register access port
// Assumes: byte-wide registers, 15-bit address, 24-bit frames
// Notes:   indices below are byte addresses seen on the serial link
package sra_pkg;

	localparam int ADDR_W    = 15;
	localparam int DATA_W    = 8;
	localparam int HDR_BITS  = 16;
	localparam int BYTE_BITS = 8;
	localparam int CORES     = 6;
	localparam int INPUTS    = 4;
	localparam int REG_COUNT = 26;

	// register byte indices
	localparam int IDX_CFG     = 0;
	localparam int IDX_BANDGAP = 1;
	localparam int IDX_TERM    = 2;
	localparam int IDX_OFS     = 6;
	localparam int IDX_GAIN    = 18;
	localparam int IDX_FS      = 24;

	// config byte fields
	localparam int CFG_DESC_BIT = 0;
	localparam int CFG_HOLD_BIT = 1;

	// reset values
	localparam logic [7:0]  RST_CFG     = 8'h00;
	localparam logic [7:0]  RST_BANDGAP = 8'h80;
	localparam logic [7:0]  RST_TERM    = 8'h80;
	localparam logic [15:0] RST_OFS     = 16'h0000;
	localparam logic [7:0]  RST_GAIN    = 8'h80;
	localparam logic [15:0] RST_FS      = 16'h8000;
	// {sdi, sclk, chip_select_n} idle levels
	localparam logic [2:0]  PIN_RST     = 3'b001;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_HEADER = 2'b01,
		ST_DATA   = 2'b10,
		ST_HALT   = 2'b11
	} frame_state_t;

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		return int'(a) < REG_COUNT;
	endfunction

	function automatic logic [7:0] reset_byte(input int i);
		logic [7:0] v;
		v = 8'h00;
		if (i == IDX_CFG) v = RST_CFG;
		else if (i == IDX_BANDGAP) v = RST_BANDGAP;
		else if (i < IDX_OFS) v = RST_TERM;
		else if (i < IDX_GAIN) v = ((i - IDX_OFS) % 2 == 1) ? RST_OFS[15:8] : RST_OFS[7:0];
		else if (i < IDX_FS) v = RST_GAIN;
		else v = (i == IDX_FS) ? RST_FS[7:0] : RST_FS[15:8];
		return v;
	endfunction

endpackage

// *** pin_sync.sv ***
// Purpose: three-stage synchroniser for the serial pins
// Assumes: pins are asynchronous to clk
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync import sra_pkg::*; (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// raw pins and filtered levels
	input  wire logic [2:0] pin_in,
	output var  logic [2:0] pin_out
);

	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!resetn) begin
					s1_r[g]    <= PIN_RST[g];
					s2_r[g]    <= PIN_RST[g];
					s3_r[g]    <= PIN_RST[g];
					pin_out[g] <= PIN_RST[g];
				end else begin
					s1_r[g] <= pin_in[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						pin_out[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// *** reg_store.sv ***
// Purpose: byte register file holding config and trim values
// Assumes: one serial write port, one calibration port for offsets
// Notes:   calibration update wins over a serial write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module reg_store import sra_pkg::*; (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// serial access
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [7:0]        wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [7:0]        rd_data,
	// offset calibration
	input  wire logic              offset_cal_enable,
	input  wire logic              cal_ofs_wr,
	input  wire logic [2:0]        cal_ofs_core,
	input  wire logic [15:0]       cal_ofs_value,
	// variant strap
	input  wire logic [INPUTS-1:0] chan_present,
	// register contents
	output logic                   address_direction_sel,
	output logic                   stream_disable,
	output logic      [7:0]        bandgap_trim,
	output var  logic [31:0]       termination_trim,
	output logic      [95:0]       core_offset_trim,
	output logic      [47:0]       core_gain_trim,
	output logic      [15:0]       fullscale_adjust
);

	logic [7:0]        mem_r [REG_COUNT];
	logic [INPUTS-1:0] present_r;

	assign rd_data = addr_ok(rd_addr) ? mem_r[rd_addr[4:0]] : 8'h00;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				mem_r[i] <= reset_byte(i);
			end
		end else begin
			// gain bytes are reached only through this serial path
			if (wr_en && addr_ok(wr_addr)) begin
				mem_r[wr_addr[4:0]] <= wr_data; // R16
			end
			if (cal_ofs_wr && offset_cal_enable && cal_ofs_core < 3'h6) begin
				mem_r[IDX_OFS + 2 * int'(cal_ofs_core)]     <= cal_ofs_value[7:0]; // R6
				mem_r[IDX_OFS + 2 * int'(cal_ofs_core) + 1] <= cal_ofs_value[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) present_r <= '0;
		else present_r <= chan_present;
	end

	assign address_direction_sel = mem_r[IDX_CFG][CFG_DESC_BIT];
	assign stream_disable        = mem_r[IDX_CFG][CFG_HOLD_BIT];
	assign bandgap_trim          = mem_r[IDX_BANDGAP];
	assign fullscale_adjust      = {mem_r[IDX_FS + 1], mem_r[IDX_FS]}; // R6 R19

	genvar g;
	generate
		for (g = 0; g < CORES; g++) begin : g_core
			assign core_offset_trim[g*16 +: 16] = {mem_r[IDX_OFS + 2*g + 1], mem_r[IDX_OFS + 2*g]}; // R18
			assign core_gain_trim[g*8 +: 8]     = mem_r[IDX_GAIN + g];
		end
		for (g = 0; g < INPUTS; g++) begin : g_term
			// absent inputs keep their byte but drive nothing
			always_ff @(posedge clk) begin
				if (!resetn) termination_trim[g*8 +: 8] <= 8'h00;
				else termination_trim[g*8 +: 8] <= present_r[g] ? mem_r[IDX_TERM + g] : 8'h00; // R17
			end
		end
	endgenerate

	chk_gain_kept: assert property (@(posedge clk) disable iff (!resetn)
		!$stable(core_gain_trim) |-> $past(wr_en)) // R16
		else $error("gain trim changed without serial write");

	chk_term_absent: assert property (@(posedge clk) disable iff (!resetn) // R17
		!present_r[1] |=> termination_trim[15:8] == 8'h00)
		else $error("absent input termination trim active");

endmodule
`default_nettype wire

// *** serial_register_access_port.sv ***
// Purpose: serial register access slave, 24-bit frames with streaming
// Assumes: pins asynchronous to clk; host drives sdi before sclk rises
// Notes:   sdo changes after falling sclk, host samples on rising
// Notes on behaviour
// R1: chip select low frames access, else ignored
// R2: input bits taken on rising serial clock
// R3: no minimum serial clock rate, no timeouts
// R4: one access is a 24-bit frame
// R5: all fields shifted most significant bit first
// R6: multi-byte registers stored little-endian
// R7: output undriven in writes and read header
// R8: first bit one reads, zero writes
// R9: next fifteen bits carry register address
// R10: write loads last eight bits into register
// R11: read ignores last eight, drives register out
// R12: streaming continues same direction while selected
// R13: address steps up, or down if selected
// R14: stream disable stops after first frame
// R15: host avoids access during calibration
// R16: gain trims never changed by calibration
// R17: absent input trims writable but inert
// R18: separate offset trim per core zero-five
// R19: one full-scale adjust shared by inputs
// R20: host leaves offsets alone during offset calibration
// R21: partial frame discarded, counters cleared
`timescale 1ns/1ps
`default_nettype none
module serial_register_access_port import sra_pkg::*; (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// serial pins
	input  wire logic              chip_select_n,
	input  wire logic              sclk,
	input  wire logic              sdi,
	output var  logic              sdo,
	output var  logic              sdo_oe,
	// offset calibration engine
	input  wire logic              offset_cal_enable,
	input  wire logic              cal_ofs_wr,
	input  wire logic [2:0]        cal_ofs_core,
	input  wire logic [15:0]       cal_ofs_value,
	// variant strap
	input  wire logic [INPUTS-1:0] chan_present,
	// configuration
	output logic                   address_direction_sel,
	output logic                   stream_disable,
	// trims
	output logic      [7:0]        bandgap_trim,
	output logic      [31:0]       termination_trim,
	output logic      [95:0]       core_offset_trim,
	output logic      [47:0]       core_gain_trim,
	output logic      [15:0]       fullscale_adjust
);

	// ***************************************************
	// pin sampling
	// ***************************************************

	logic [2:0] pin_s;
	logic       sclk_d_r;
	logic       cs_low;
	logic       sdi_s;
	logic       sclk_rise;
	logic       sclk_fall;

	pin_sync u_sync (
		.clk     (clk),
		.resetn  (resetn),
		.pin_in  ({sdi, sclk, chip_select_n}),
		.pin_out (pin_s)
	);

	always_ff @(posedge clk) begin
		if (!resetn) sclk_d_r <= PIN_RST[1];
		else sclk_d_r <= pin_s[1];
	end

	assign cs_low    = ~pin_s[0];
	assign sdi_s     = pin_s[2];
	assign sclk_rise = pin_s[1] & ~sclk_d_r;
	assign sclk_fall = ~pin_s[1] & sclk_d_r;

	// ***************************************************
	// frame engine
	// ***************************************************

	frame_state_t      st_r;
	logic [4:0]        hdr_cnt_r;
	logic [2:0]        bit_cnt_r;
	logic [14:0]       hdr_r;
	logic              rw_r;
	logic [ADDR_W-1:0] addr_r;
	logic [6:0]        data_r;
	logic              byte_end;

	assign byte_end = st_r == ST_DATA && sclk_rise && bit_cnt_r == 3'h7;

	// every event waits on an edge only, so a paused clock is harmless
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_r      <= ST_IDLE;
			hdr_cnt_r <= 5'h00;
			bit_cnt_r <= 3'h0;
			hdr_r     <= 15'h0000;
			rw_r      <= 1'b0;
			addr_r    <= '0;
			data_r    <= 7'h00;
		end else if (!cs_low) begin
			st_r      <= ST_IDLE; // R1 R21
			hdr_cnt_r <= 5'h00;
			bit_cnt_r <= 3'h0;
		end else begin
			case (st_r)
				ST_IDLE, ST_HEADER: begin
					st_r <= ST_HEADER;
					if (sclk_rise) begin // R2 R3
						hdr_r     <= {hdr_r[13:0], sdi_s}; // R5
						hdr_cnt_r <= hdr_cnt_r + 5'h01;
						if (hdr_cnt_r == 5'(HDR_BITS - 1)) begin
							st_r   <= ST_DATA;
							rw_r   <= hdr_r[14]; // R8
							addr_r <= {hdr_r[13:0], sdi_s}; // R9
						end
					end
				end
				ST_DATA: begin
					if (sclk_rise) begin
						data_r    <= {data_r[5:0], sdi_s};
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r == 3'(BYTE_BITS - 1)) begin
							bit_cnt_r <= 3'h0;
							if (stream_disable) begin
								st_r <= ST_HALT; // R14
							end else if (address_direction_sel) begin
								addr_r <= addr_r - 15'h0001; // R12 R13
							end else begin
								addr_r <= addr_r + 15'h0001; // R13
							end
						end
					end
				end
				ST_HALT: begin
					st_r <= ST_HALT;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ***************************************************
	// register write
	// ***************************************************

	logic              wr_stb_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [7:0]        wr_data_r;
	logic [7:0]        rd_data;

	// a write lands only when all 24 bits have arrived
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_stb_r  <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= 8'h00;
		end else begin
			wr_stb_r <= cs_low && byte_end && !rw_r; // R4 R10 R21
			if (cs_low && byte_end) begin
				wr_addr_r <= addr_r;
				wr_data_r <= {data_r, sdi_s}; // R5 R10
			end
		end
	end

	reg_store u_regs (
		.clk                   (clk),
		.resetn                (resetn),
		.wr_en                 (wr_stb_r),
		.wr_addr               (wr_addr_r),
		.wr_data               (wr_data_r),
		.rd_addr               (addr_r),
		.rd_data               (rd_data),
		.offset_cal_enable     (offset_cal_enable),
		.cal_ofs_wr            (cal_ofs_wr),
		.cal_ofs_core          (cal_ofs_core),
		.cal_ofs_value         (cal_ofs_value),
		.chan_present          (chan_present),
		.address_direction_sel (address_direction_sel),
		.stream_disable        (stream_disable),
		.bandgap_trim          (bandgap_trim),
		.termination_trim      (termination_trim),
		.core_offset_trim      (core_offset_trim),
		.core_gain_trim        (core_gain_trim),
		.fullscale_adjust      (fullscale_adjust)
	);

	// ***************************************************
	// read data out
	// ***************************************************

	logic [6:0] sh_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sdo    <= 1'b0;
			sdo_oe <= 1'b0;
			sh_r   <= 7'h00;
		end else if (!cs_low || st_r != ST_DATA || !rw_r) begin
			sdo    <= 1'b0; // R7
			sdo_oe <= 1'b0;
		end else if (sclk_fall) begin
			sdo_oe <= 1'b1; // R11
			if (bit_cnt_r == 3'h0) begin
				sdo  <= rd_data[7]; // R5 R11
				sh_r <= rd_data[6:0];
			end else begin
				sdo  <= sh_r[6];
				sh_r <= {sh_r[5:0], 1'b0};
			end
		end
	end

	// ***************************************************
	// checks
	// ***************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// header and shifter taps watched by the checks
	logic              hdr_done;
	logic              hdr_rw;
	logic [ADDR_W-1:0] hdr_addr;
	logic              sh_msb;

	assign hdr_done = st_r == ST_HEADER && cs_low && sclk_rise && hdr_cnt_r == 5'(HDR_BITS - 1);
	assign hdr_rw   = hdr_r[14];
	assign hdr_addr = {hdr_r[13:0], sdi_s};
	assign sh_msb   = sh_r[6];

	sequence seq_hdr_done;
		hdr_done;
	endsequence

	sequence seq_read_shift;
		cs_low && sclk_fall && st_r == ST_DATA && rw_r && bit_cnt_r != 3'h0;
	endsequence

	sequence seq_byte_end;
		cs_low && byte_end;
	endsequence

	sequence seq_read_load;
		cs_low && sclk_fall && st_r == ST_DATA && rw_r && bit_cnt_r == 3'h0;
	endsequence

	chk_cs_high_idle: assert property (!cs_low |=> st_r == ST_IDLE && !sdo_oe) // R1
		else $error("not idle while deselected");

	chk_rise_only: assert property ((st_r == ST_HEADER && cs_low && !sclk_rise) |=> $stable(hdr_cnt_r)) // R2
		else $error("header counted without rising edge");

	chk_pause_hold: assert property ((st_r == ST_DATA && cs_low && !sclk_rise)[*8] |=> $stable(bit_cnt_r)) // R3
		else $error("data count moved while clock paused");

	chk_write_commit: assert property (seq_byte_end ##0 !rw_r |=> wr_stb_r && wr_addr_r == $past(addr_r)) // R10
		else $error("write byte not committed");

	chk_read_silent: assert property (seq_byte_end ##0 rw_r |=> !wr_stb_r) // R11
		else $error("read frame wrote a register");

	chk_sdo_quiet: assert property ((st_r != ST_DATA || !rw_r) |=> !sdo_oe) // R7
		else $error("sdo driven outside read data");

	chk_sdo_msb: assert property (seq_read_load |=> sdo == $past(rd_data[7]) && sdo_oe) // R5
		else $error("read byte does not start at msb");

	chk_addr_step: assert property (seq_byte_end ##0 !stream_disable |=> // R13
		addr_r == ($past(address_direction_sel) ? $past(addr_r) - 15'h0001 : $past(addr_r) + 15'h0001))
		else $error("stream address step wrong");

	chk_stream_on: assert property (seq_byte_end ##0 !stream_disable |=> st_r == ST_DATA) // R12
		else $error("stream stopped early");

	chk_hold_halt: assert property (seq_byte_end ##0 stream_disable |=> st_r == ST_HALT && $stable(addr_r)) // R14
		else $error("stream continued while disabled");

	chk_partial_drop: assert property ((st_r == ST_HEADER && !cs_low) |=> !wr_stb_r ##0 hdr_cnt_r == 5'h00) // R21
		else $error("partial frame not discarded");

	chk_header_len: assert property (seq_hdr_done |=> st_r == ST_DATA && bit_cnt_r == 3'h0) // R4 R9
		else $error("header length wrong");

	chk_dir_capture: assert property (seq_hdr_done |=> rw_r == $past(hdr_rw)) // R8
		else $error("direction bit not captured");

	chk_addr_capture: assert property (seq_hdr_done |=> addr_r == $past(hdr_addr)) // R9
		else $error("header address not captured");

	chk_sdo_shift: assert property (seq_read_shift |=> sdo == $past(sh_msb) && sdo_oe) // R5 R11
		else $error("read byte bit order wrong");

	chk_halt_quiet: assert property ((st_r == ST_HALT && cs_low) |=> // R14
		st_r == ST_HALT && !wr_stb_r && $stable(addr_r))
		else $error("halted frame still active");

	chk_cs_counts: assert property (!cs_low |=> hdr_cnt_r == 5'h00 && bit_cnt_r == 3'h0) // R1 R21
		else $error("counters not cleared while deselected");

endmodule
`default_nettype wire

// *** spi_host_model.sv ***
// Purpose: host model driving the serial register link
// Assumes: sclk period 125 ns, sclk idles low between frames
// Notes:   sdi shows the inverted last bit while deselected
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// serial pins
	output var  logic chip_select_n,
	output var  logic sclk,
	output var  logic sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	logic [7:0] wd [0:31];
	logic [7:0] rx_byte;
	logic       oe_bad;
	event       byte_ev;

	initial begin
		chip_select_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		oe_bad = 1'b0;
		rx_byte = 8'h00;
	end

	// one framed access; cut drops trailing bits
	task automatic xfer(input logic rw, input logic [14:0] a, input int nb, input int cut);
		logic [15:0] hdr;
		logic [7:0]  sh;
		int          n;
		hdr = {rw, a};
		sh = 8'h00;
		n = 16 + 8 * nb - cut;
		chip_select_n = 1'b0;
		#62.5;
		for (int i = 0; i < n; i++) begin
			sdi = (i < 16) ? hdr[15 - i] : wd[(i - 16) / 8][7 - (i % 8)];
			#62.5;
			sclk = 1'b1;
			if (sdo_oe !== (rw && i >= 16))
				oe_bad = 1'b1;
			sh = {sh[6:0], sdo};
			if (rw && i >= 16 && i % 8 == 7) begin
				rx_byte = sh;
				->byte_ev;
			end
			#62.5;
			sclk = 1'b0;
		end
		#62.5;
		chip_select_n = 1'b1;
		sdi = ~sdi;
		#100;
	endtask
endmodule
`default_nettype wire

// *** serial_register_access_port_tb_top.sv ***
// Purpose: self-checking bench for the serial register access port
// Assumes: byte registers at addresses 0..25, reads of trims give stored bytes
// Notes:   serial reads are scored through a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none
module serial_register_access_port_tb_top import sra_pkg::*;;
	logic              clk = 1'b0;
	logic              resetn;
	logic              chip_select_n;
	logic              sclk;
	logic              sdi;
	logic              sdo;
	logic              sdo_oe;
	logic              offset_cal_enable;
	logic              cal_ofs_wr;
	logic [2:0]        cal_ofs_core;
	logic [15:0]       cal_ofs_value;
	logic [INPUTS-1:0] chan_present;
	logic              address_direction_sel;
	logic              stream_disable;
	logic [7:0]        bandgap_trim;
	logic [31:0]       termination_trim;
	logic [95:0]       core_offset_trim;
	logic [47:0]       core_gain_trim;
	logic [15:0]       fullscale_adjust;
	logic [7:0]        mem [0:REG_COUNT-1];
	logic [7:0]        exp_q [$];
	logic [31:0]       seed = 32'h7f89;
	int                failures = 0;
	int                check_count = 0;

	always #4 clk = ~clk;

	serial_register_access_port uut (.clk(clk), .resetn(resetn), .chip_select_n(chip_select_n), .sclk(sclk),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .offset_cal_enable(offset_cal_enable), .cal_ofs_wr(cal_ofs_wr),
		.cal_ofs_core(cal_ofs_core), .cal_ofs_value(cal_ofs_value), .chan_present(chan_present),
		.address_direction_sel(address_direction_sel), .stream_disable(stream_disable),
		.bandgap_trim(bandgap_trim), .termination_trim(termination_trim), .core_offset_trim(core_offset_trim),
		.core_gain_trim(core_gain_trim), .fullscale_adjust(fullscale_adjust));

	spi_host_model host (.chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmpv(input logic [95:0] got, input logic [95:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk_ports();
		for (int k = 0; k < CORES; k++) begin
			cmpv(core_offset_trim[16*k +: 16], {mem[IDX_OFS+2*k+1], mem[IDX_OFS+2*k]});
			cmpv(core_gain_trim[8*k +: 8], mem[IDX_GAIN+k]);
		end
		for (int k = 0; k < INPUTS; k++)
			cmpv(termination_trim[8*k +: 8], chan_present[k] ? mem[IDX_TERM+k] : 8'h00);
		cmpv(bandgap_trim, mem[IDX_BANDGAP]);
		cmpv(fullscale_adjust, {mem[IDX_FS+1], mem[IDX_FS]});
		cmpv({stream_disable, address_direction_sel}, mem[IDX_CFG][1:0]);
	endtask

	task automatic rd(input logic [14:0] a, input int nb);
		logic [14:0] p;
		p = a;
		for (int j = 0; j < nb; j++) begin
			exp_q.push_back(p < REG_COUNT ? mem[p] : 8'h00);
			p = mem[IDX_CFG][CFG_DESC_BIT] ? p - 15'h0001 : p + 15'h0001;
		end
		host.xfer(1'b1, a, nb, 0);
	endtask

	task automatic wr(input logic [14:0] a, input int nb, input logic [7:0] d0, input int cut);
		logic [14:0] p;
		int          eff;
		p = a;
		eff = (8 * nb >= cut) ? (8 * nb - cut) / 8 : 0;
		if (mem[IDX_CFG][CFG_HOLD_BIT] && eff > 1)
			eff = 1;
		for (int j = 0; j < nb; j++)
			host.wd[j] = (j == 0) ? d0 : 8'(rnd());
		for (int j = 0; j < eff; j++) begin
			if (p < REG_COUNT)
				mem[p] = host.wd[j];
			p = mem[IDX_CFG][CFG_DESC_BIT] ? p - 15'h0001 : p + 15'h0001;
		end
		host.xfer(1'b0, a, nb, cut);
	endtask

	task automatic cal(input logic en, input logic [2:0] c, input logic [15:0] v);
		@(negedge clk);
		offset_cal_enable = en;
		cal_ofs_wr = 1'b1;
		cal_ofs_core = c;
		cal_ofs_value = v;
		@(negedge clk);
		cal_ofs_wr = 1'b0;
		if (en && c < CORES) begin
			mem[IDX_OFS+2*c] = v[7:0];
			mem[IDX_OFS+2*c+1] = v[15:8];
		end
		@(negedge clk);
		chk_ports();
	endtask

	always @(host.byte_ev) begin
		cmpv(exp_q.size() > 0, 1'b1);
		if (exp_q.size() > 0)
			cmp8(host.rx_byte, exp_q.pop_front());
	end

	initial begin
		#500000;
		failures++;
		stop_test();
	end

	initial begin
		resetn = 1'b0;
		offset_cal_enable = 1'b0;
		cal_ofs_wr = 1'b0;
		cal_ofs_core = 3'h0;
		cal_ofs_value = 16'h0000;
		chan_present = 4'h3;
		for (int i = 0; i < REG_COUNT; i++)
			mem[i] = 8'h00;
		mem[IDX_CFG] = RST_CFG;
		mem[IDX_BANDGAP] = RST_BANDGAP;
		for (int k = 0; k < INPUTS; k++)
			mem[IDX_TERM+k] = RST_TERM;
		for (int k = 0; k < CORES; k++) begin
			mem[IDX_OFS+2*k] = RST_OFS[7:0];
			mem[IDX_OFS+2*k+1] = RST_OFS[15:8];
			mem[IDX_GAIN+k] = RST_GAIN;
		end
		mem[IDX_FS] = RST_FS[7:0];
		mem[IDX_FS+1] = RST_FS[15:8];
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		chk_ports();
		rd(15'h0000, 26);
		wr(15'h0001, 25, 8'(rnd()), 0);
		chk_ports();
		rd(15'h0001, 25);
		// descending stream
		wr(15'h0000, 1, 8'h01, 0);
		rd(15'h0019, 8);
		wr(15'h0011, 12, 8'(rnd()), 0);
		chk_ports();
		// stream disable stops after one byte
		wr(15'h0000, 1, 8'h02, 0);
		wr(15'h0001, 3, 8'(rnd()), 0);
		rd(15'h0001, 1);
		chk_ports();
		wr(15'h0000, 1, 8'h00, 0);
		// partial frames
		wr(15'h0001, 1, 8'(rnd()), 3);
		wr(15'h0002, 2, 8'(rnd()), 3);
		wr(15'h0003, 1, 8'(rnd()), 12);
		chk_ports();
		rd(15'h0001, 3);
		// unmapped places
		wr(15'h7fff, 1, 8'(rnd()), 0);
		rd(15'h7fff, 1);
		rd(15'h0040, 1);
		cal(1'b1, 3'h3, 16'(rnd()));
		cal(1'b1, 3'h5, 16'(rnd()));
		cal(1'b0, 3'h1, 16'(rnd()));
		cal(1'b1, 3'h6, 16'(rnd()));
		offset_cal_enable = 1'b0;
		rd(15'h0006, 12);
		@(negedge clk);
		chan_present = 4'h5;
		repeat (4) @(negedge clk);
		chk_ports();
		cmpv(host.oe_bad, 1'b0);
		cmpv(sdo_oe, 1'b0);
		cmpv(exp_q.size(), 0);
		stop_test();
	end
endmodule
`default_nettype wire
